// ==== src/swri_pkg.sv ====
package swri_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 40000000;
  // Ring pulse timing for an incoming call, in ms
  localparam int unsigned CALL_PULSE_MS = 30;
  localparam int unsigned CALL_PERIOD_MS = 5000;
  // Ring pulse for a received message, in ms
  localparam int unsigned MSG_PULSE_MS = 35;
  // Grace time awake after a wake event with DTR low, in ms
  localparam int unsigned WAKE_HOLD_MS = 100;
  // Cycle counts derived from the times
  localparam int unsigned CALL_PULSE_CYC = CALL_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned CALL_PERIOD_CYC = CALL_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned MSG_PULSE_CYC = MSG_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_HOLD_CYC = WAKE_HOLD_MS * (CLK_HZ / 1000);
  // Counter width, enough for the 5 s period
  localparam int unsigned CNT_W = 28;
  // LED blink half periods per pattern, in cycles
  localparam int unsigned LED_SLOW_CYC = 20000000;
  localparam int unsigned LED_FAST_CYC = 4000000;
  // Power states
  typedef enum logic [1:0] {
    SWRI_AWAKE = 2'b00,
    SWRI_DRAIN = 2'b01,
    SWRI_SLEEP = 2'b10,
    SWRI_WOKEN = 2'b11
  } swri_pwr_t;
  // Ring output states
  typedef enum logic [1:0] {
    SWRI_RIDLE = 2'b00,
    SWRI_CALL_LOW = 2'b01,
    SWRI_CALL_HIGH = 2'b10,
    SWRI_MSG_LOW = 2'b11
  } swri_ring_t;
endpackage

// ==== src/swri_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - DTR input controls sleep; ring is output
// - Armed and DTR low: sleep after work drains
// - Events still detected while asleep
// - Wake events notify host via ring/serial
// - DTR still low after wake: sleep again
// - Rising DTR leaves sleep, enables serial
// - Call: 30 ms low pulse every 5 s
// - Answered call stops pulsing, ring high
// - Message: single 35 ms low pulse
// - Status LED off, on, or blinking slow/fast per selectable pattern
module swri_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Host control line
  input wire logic DTR,
  // Settings from the command parser
  input wire logic POWER_SAVE_ARM_COMMAND,
  input wire logic [1:0] LED_PATTERN_SEL,
  // Module activity
  input wire logic BUSY,
  input wire logic CALL_EVENT,
  input wire logic CALL_ANSWERED,
  input wire logic MSG_EVENT,
  input wire logic DATA_EVENT,
  // Outputs
  output logic RING_N,
  output logic SLEEP,
  output logic SERIAL_EN,
  output logic WAKE_NOTIFY,
  output logic STATUS_LED_OUT
);
  swri_pkg::swri_pwr_t pwr, next_pwr;
  swri_pkg::swri_ring_t ring, next_ring;
  logic [swri_pkg::CNT_W-1:0] hold_cnt, next_hold_cnt;
  logic [swri_pkg::CNT_W-1:0] ring_cnt, next_ring_cnt;
  logic [swri_pkg::CNT_W-1:0] led_cnt, next_led_cnt;
  logic next_ring_n, next_sleep, next_serial_en, next_wake_notify;
  logic next_led;
  logic led_phase, next_led_phase;
  logic dtr_q, next_dtr_q;
  logic any_event;

  // Size a count constant to the counter width
  function automatic logic [swri_pkg::CNT_W-1:0] cyc(input int unsigned n);
    cyc = swri_pkg::CNT_W'(n - 1);
  endfunction

  assign any_event = CALL_EVENT | MSG_EVENT | DATA_EVENT;

  // Power state sequencing
  always_comb
  begin
    next_pwr = pwr;
    next_hold_cnt = hold_cnt;
    next_wake_notify = 1'b0;
    next_dtr_q = DTR;
    case (pwr)
      swri_pkg::SWRI_AWAKE:
      begin
        if (POWER_SAVE_ARM_COMMAND && !DTR)
          next_pwr = swri_pkg::SWRI_DRAIN;
      end
      swri_pkg::SWRI_DRAIN:
      begin
        if (DTR)
          next_pwr = swri_pkg::SWRI_AWAKE;
        else if (!BUSY)
          next_pwr = swri_pkg::SWRI_SLEEP;
      end
      swri_pkg::SWRI_SLEEP:
      begin
        if (DTR && !dtr_q)
          next_pwr = swri_pkg::SWRI_AWAKE;
        else if (any_event)
        begin
          next_pwr = swri_pkg::SWRI_WOKEN;
          next_wake_notify = 1'b1;
          next_hold_cnt = cyc(swri_pkg::WAKE_HOLD_CYC);
        end
      end
      swri_pkg::SWRI_WOKEN:
      begin
        if (DTR)
          next_pwr = swri_pkg::SWRI_AWAKE;
        else if (hold_cnt == '0)
          next_pwr = swri_pkg::SWRI_DRAIN;
        else
          next_hold_cnt = hold_cnt - 1'b1;
      end
      default: next_pwr = swri_pkg::SWRI_AWAKE;
    endcase
    if (!POWER_SAVE_ARM_COMMAND && next_pwr != swri_pkg::SWRI_WOKEN)
      next_pwr = swri_pkg::SWRI_AWAKE;
    next_sleep = (next_pwr == swri_pkg::SWRI_SLEEP);
    next_serial_en = !next_sleep;
  end

  // Ring pulse generation
  always_comb
  begin
    next_ring = ring;
    next_ring_cnt = ring_cnt;
    case (ring)
      swri_pkg::SWRI_RIDLE:
      begin
        if (CALL_EVENT && !CALL_ANSWERED)
        begin
          next_ring = swri_pkg::SWRI_CALL_LOW;
          next_ring_cnt = cyc(swri_pkg::CALL_PULSE_CYC);
        end
        else if (MSG_EVENT)
        begin
          next_ring = swri_pkg::SWRI_MSG_LOW;
          next_ring_cnt = cyc(swri_pkg::MSG_PULSE_CYC);
        end
      end
      swri_pkg::SWRI_CALL_LOW:
      begin
        if (CALL_ANSWERED)
          next_ring = swri_pkg::SWRI_RIDLE;
        else if (ring_cnt == '0)
        begin
          next_ring = swri_pkg::SWRI_CALL_HIGH;
          next_ring_cnt = cyc(swri_pkg::CALL_PERIOD_CYC - swri_pkg::CALL_PULSE_CYC);
        end
        else
          next_ring_cnt = ring_cnt - 1'b1;
      end
      swri_pkg::SWRI_CALL_HIGH:
      begin
        if (CALL_ANSWERED)
          next_ring = swri_pkg::SWRI_RIDLE;
        else if (ring_cnt == '0)
        begin
          next_ring = swri_pkg::SWRI_CALL_LOW;
          next_ring_cnt = cyc(swri_pkg::CALL_PULSE_CYC);
        end
        else
          next_ring_cnt = ring_cnt - 1'b1;
      end
      swri_pkg::SWRI_MSG_LOW:
      begin
        if (ring_cnt == '0)
          next_ring = swri_pkg::SWRI_RIDLE;
        else
          next_ring_cnt = ring_cnt - 1'b1;
      end
      default: next_ring = swri_pkg::SWRI_RIDLE;
    endcase
    // Low only during a pulse phase
    next_ring_n = !(next_ring == swri_pkg::SWRI_CALL_LOW ||
                    next_ring == swri_pkg::SWRI_MSG_LOW);
  end

  // Status status_led_out blink patterns: 0 off, 1 on, 2 slow, 3 fast
  always_comb
  begin
    next_led_cnt = led_cnt - 1'b1;
    next_led_phase = led_phase;
    if (led_cnt == '0)
    begin
      next_led_phase = !led_phase;
      next_led_cnt = (LED_PATTERN_SEL == 2'h3) ? cyc(swri_pkg::LED_FAST_CYC)
                                               : cyc(swri_pkg::LED_SLOW_CYC);
    end
    case (LED_PATTERN_SEL)
      2'h0: next_led = 1'b0;
      2'h1: next_led = 1'b1;
      default: next_led = next_led_phase;
    endcase
  end

  // Power state registers; DTR history resets to its idle high level
  // so that no false rising edge follows reset
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pwr <= swri_pkg::SWRI_AWAKE;
      hold_cnt <= '0;
      dtr_q <= 1'b1;
      SLEEP <= 1'b0;
      SERIAL_EN <= 1'b1;
      WAKE_NOTIFY <= 1'b0;
    end
    else
    begin
      pwr <= next_pwr;
      hold_cnt <= next_hold_cnt;
      dtr_q <= next_dtr_q;
      SLEEP <= next_sleep;
      SERIAL_EN <= next_serial_en;
      WAKE_NOTIFY <= next_wake_notify;
    end
  end

  // Ring pulse registers; the line rests high out of reset
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ring <= swri_pkg::SWRI_RIDLE;
      ring_cnt <= '0;
      RING_N <= 1'b1;
    end
    else
    begin
      ring <= next_ring;
      ring_cnt <= next_ring_cnt;
      RING_N <= next_ring_n;
    end
  end

  // Status status_led_out registers; an expired counter starts the first blink at once
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      led_cnt <= '0;
      led_phase <= 1'b0;
      STATUS_LED_OUT <= 1'b0;
    end
    else
    begin
      led_cnt <= next_led_cnt;
      led_phase <= next_led_phase;
      STATUS_LED_OUT <= next_led;
    end
  end
endmodule

// ==== tb/swri_host.sv ====
`timescale 1ns/1ps
module swri_host (
  // Clock
  input wire logic clk,
  // Bench request and line to the block
  input wire logic stay_awake,
  output logic dtr
);
  // DTR is held high while the host needs the module awake
  initial dtr = 1'b1;
  always @(posedge clk)
  begin
    dtr <= #1 stay_awake;
  end
endmodule

// ==== tb/swri_checker.sv ====
`timescale 1ns/1ps
module swri_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Watched ports
  input wire logic DTR,
  input wire logic POWER_SAVE_ARM_COMMAND,
  input wire logic BUSY,
  input wire logic CALL_EVENT,
  input wire logic CALL_ANSWERED,
  input wire logic MSG_EVENT,
  input wire logic DATA_EVENT,
  input wire logic RING_N,
  input wire logic SLEEP,
  input wire logic SERIAL_EN,
  input wire logic WAKE_NOTIFY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic [27:0] low_cnt;
  logic ev;
  // Any wake event
  assign ev = CALL_EVENT || MSG_EVENT || DATA_EVENT;
  // Length of the current low ring pulse
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      low_cnt <= 28'h0;
    else
      low_cnt <= RING_N ? 28'h0 : low_cnt + 28'h1;
  end
  // Armed, host low, nothing pending
  sequence s_quiet;
    POWER_SAVE_ARM_COMMAND && !DTR && !BUSY && !ev;
  endsequence
  a_sleep_entry: assert property ($fell(DTR) ##0 s_quiet ##1 s_quiet[*3] |=> ##[0:2] SLEEP)
    else $error("no sleep after DTR low");
  a_busy_holds: assert property (BUSY ##1 BUSY && !SLEEP |=> !SLEEP)
    else $error("slept while busy");
  a_unarmed_awake: assert property (!POWER_SAVE_ARM_COMMAND [*4] |-> !SLEEP)
    else $error("slept while not armed");
  a_dtr_high_awake: assert property (DTR [*4] |-> !SLEEP && SERIAL_EN)
    else $error("asleep with DTR high");
  a_serial_follow: assert property (SERIAL_EN != SLEEP)
    else $error("serial enable wrong");
  a_event_wakes: assert property (SLEEP && !DTR && ev |-> ##[1:3] WAKE_NOTIFY)
    else $error("event did not wake");
  a_notify_single: assert property (WAKE_NOTIFY |=> !WAKE_NOTIFY)
    else $error("wake notify too long");
  a_pulse_len: assert property ($rose(RING_N) && !$past(CALL_ANSWERED) |->
    low_cnt == 28'(swri_pkg::CALL_PULSE_CYC) || low_cnt == 28'(swri_pkg::MSG_PULSE_CYC))
    else $error("ring pulse length wrong");
endmodule

bind swri_top swri_checker chk (.CLK(CLK), .SYS_RST(SYS_RST), .DTR(DTR),
  .POWER_SAVE_ARM_COMMAND(POWER_SAVE_ARM_COMMAND), .BUSY(BUSY), .CALL_EVENT(CALL_EVENT),
  .CALL_ANSWERED(CALL_ANSWERED), .MSG_EVENT(MSG_EVENT), .DATA_EVENT(DATA_EVENT),
  .RING_N(RING_N), .SLEEP(SLEEP), .SERIAL_EN(SERIAL_EN), .WAKE_NOTIFY(WAKE_NOTIFY));

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, arm = 0, busy = 0, cev = 0, cans = 0, mev = 0, dev = 0, awake = 1;
  logic ring_n, sleep, ser_en, wake, dtr;
  logic [1:0] led_sel = 2'h3;
  logic led;
  int err_total = 0;
  int n_checks = 0;
  swri_host host (.clk(clk), .stay_awake(awake), .dtr(dtr));
  swri_top dut (.CLK(clk), .SYS_RST(rst), .DTR(dtr), .POWER_SAVE_ARM_COMMAND(arm),
    .LED_PATTERN_SEL(led_sel), .BUSY(busy), .CALL_EVENT(cev), .CALL_ANSWERED(cans),
    .MSG_EVENT(mev), .DATA_EVENT(dev), .RING_N(ring_n), .SLEEP(sleep),
    .SERIAL_EN(ser_en), .WAKE_NOTIFY(wake), .STATUS_LED_OUT(led));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Step past n edges, then settle
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task give_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Event wakes, host raises DTR, then lowers it again
  task t_wake;
    dev = 1;
    cyc(1);
    chk("notify", wake, 1'b1);
    dev = 0;
    cyc(1);
    chk("notify_end", wake, 1'b0);
    cyc(3);
    chk("woken", sleep, 1'b0);
    awake = 1;
    cyc(5);
    chk("serial", ser_en, 1'b1);
    awake = 0;
    cyc(8);
    chk("resleep", sleep, 1'b1);
  endtask
  // Rising DTR leaves sleep, falling DTR returns to it
  task t_exit;
    awake = 1;
    cyc(3);
    chk("exit_sleep", sleep, 1'b0);
    chk("exit_serial", ser_en, 1'b1);
    awake = 0;
    cyc(6);
    chk("reenter", sleep, 1'b1);
  endtask
  // Fixed patterns follow the selection; blink patterns are in their lit half
  task t_led;
    led_sel = 2'h0;
    cyc(1);
    chk("led_off", led, 1'b0);
    led_sel = 2'h1;
    cyc(1);
    chk("led_on", led, 1'b1);
    led_sel = 2'h2;
    cyc(1);
    chk("led_slow", led, 1'b1);
    led_sel = 2'h3;
    cyc(1);
    chk("led_fast", led, 1'b1);
  endtask
  // Pulse input for one cycle, ring must go low
  task t_ring(input logic call);
    cev = call;
    mev = !call;
    cyc(1);
    cev = 0;
    mev = 0;
    cyc(1);
    chk("ring_low", ring_n, 1'b0);
    cyc(1500);
    chk("ring_hold", ring_n, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    cyc(6);
    chk("init_sleep", sleep, 1'b0);
    chk("init_ring", ring_n, 1'b1);
    rst = 0;
    awake = 0;
    cyc(8);
    chk("unarmed", sleep, 1'b0);
    arm = 1;
    busy = 1;
    cyc(20);
    chk("busy_awake", sleep, 1'b0);
    busy = 0;
    cyc(8);
    chk("asleep", sleep, 1'b1);
    t_exit;
    t_wake;
    t_ring(1'b1);
    cans = 1;
    cyc(1);
    chk("answered", ring_n, 1'b1);
    cans = 0;
    cyc(50);
    chk("idle", ring_n, 1'b1);
    t_ring(1'b0);
    t_led;
    rst = 1;
    cyc(1);
    chk("rst_ring", ring_n, 1'b1);
    give_verdict;
  end
  // Watchdog
  initial
  begin
    #500000;
    err_total++;
    give_verdict;
  end
endmodule
